// [verilog/transceiver_interrupt_flags.sv]
`timescale 1ns/1ps

module transceiver_interrupt_flags #(
	parameter int FRAME_THRESHOLD_P = flag_bank_pkg::FRAME_THRESHOLD,
	parameter int TRIM_ATTEMPTS_P = flag_bank_pkg::TRIM_ATTEMPTS
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port behind the serial configuration port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Device events.
	input wire flag_bank_pkg::event_t events,
	input wire flag_bank_pkg::sleep_entry_t sleep_entry,
	input wire logic serial_status_error,
	input wire logic [6:0] bus_fault_events,
	input wire logic in_sleep,
	// Partial wake control.
	input wire logic partial_wake_enable_req,
	output logic partial_wake_enable,
	output logic partial_wake_config_done,
	// Trim store loader.
	output logic trim_load_req,
	input wire flag_bank_pkg::trim_result_t trim_result,
	output logic trim_busy,
	// Summary of all flags.
	output logic any_flag
);
	import flag_bank_pkg::*;

	typedef enum logic [1:0] {TRIM_IDLE, TRIM_LOAD, TRIM_WAIT} trim_state_t;

	logic [7:0] wake_fault_ff;
	logic [7:0] power_thermal_ff;
	logic [7:0] system_error_ff;
	logic [7:0] bus_fault_ff;
	logic config_done_ff;
	logic enable_ff;
	logic serial_err_seen_ff;
	logic [7:0] frame_count_ff;
	logic [7:0] rdata_ff;
	logic any_ff;
	trim_state_t trim_state_ff;
	logic [3:0] trim_tries_ff;
	logic trim_req_ff;
	logic trim_busy_ff;
	logic trim_pending_ff;
	logic trim_fail;

	logic [7:0] set_wake_fault;
	logic [7:0] set_power_thermal;
	logic [7:0] set_system_error;
	logic partial_wake_err;
	logic frame_overflow;
	logic [7:0] system_error_view;
	logic [7:0] summary_view;

	// True when a write hits the given offset.
	function automatic logic wr_hit(input logic [7:0] addr, input logic wr,
			input logic [7:0] offset);
		wr_hit = wr && (addr == offset);
	endfunction

	// Write-one-to-clear mask for one register, restricted to its writable bits.
	function automatic logic [7:0] clr_mask(input logic [7:0] addr, input logic wr,
			input logic [7:0] data, input logic [7:0] offset, input logic [7:0] mask);
		clr_mask = wr_hit(addr, wr, offset) ? (data & mask) : 8'h00;
	endfunction

	// threshold overflow: errors past the threshold count overflow.
	assign frame_overflow = events.frame_error &&
		(frame_count_ff == 8'(FRAME_THRESHOLD_P));

	// Event sources of the first register.
	always_comb begin
		set_wake_fault = 8'h00;
		set_wake_fault[BIT_WATCHDOG] = events.watchdog;
		set_wake_fault[BIT_BUS_WAKE] = events.bus_wake;
		set_wake_fault[BIT_LOCAL_WAKE] = events.local_wake;
		set_wake_fault[BIT_WAKE_ERROR] = events.wake_window_expired && in_sleep;
		set_wake_fault[BIT_FRAME_ERROR_OVERFLOW_FLAG] = frame_overflow;
		set_wake_fault[BIT_BUS_SILENCE] = events.bus_silence;
		set_wake_fault[BIT_BUS_TIMEOUT_SLEEP] = events.bus_silence && enable_ff && in_sleep;
		set_wake_fault[BIT_STUCK_DOMINANT] = events.stuck_dominant;
	end

	// Event sources of the second register.
	always_comb begin
		set_power_thermal = 8'h00;
		set_power_thermal[BIT_SLEEP_ENTRY] = sleep_entry.entry && (sleep_entry.by_wake_error ||
			sleep_entry.by_io_uv_timeout || sleep_entry.by_io_uv_thermal);
		set_power_thermal[BIT_UV_MAIN] = events.uv_main;
		set_power_thermal[BIT_UV_IO] = events.uv_io;
		set_power_thermal[BIT_UV_XCVR] = events.uv_xcvr;
		set_power_thermal[BIT_THERMAL_SD] = events.thermal_sd;
		set_power_thermal[BIT_THERMAL_WARN] = events.thermal_warn;
	end

	// Event sources of the third register.
	always_comb begin
		set_system_error = 8'h00;
		set_system_error[BIT_SERIAL_ERR] = serial_status_error && !serial_err_seen_ff;
		set_system_error[BIT_FAILSAFE_ENTRY] = events.failsafe_entry;
		set_system_error[BIT_TRIM_CHECK_ERR] = trim_fail;
	end

	// Set wins over a clear in the same cycle, so no event is lost.
	// first register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_fault_ff <= RST_WAKE_FAULT;
		end else begin
			wake_fault_ff <= (wake_fault_ff & ~clr_mask(reg_addr, reg_wr, reg_wdata,
				ADDR_WAKE_FAULT, MASK_WAKE_FAULT)) | set_wake_fault;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_thermal_ff <= RST_POWER_THERMAL;
		end else begin
			power_thermal_ff <= (power_thermal_ff & ~clr_mask(reg_addr, reg_wr, reg_wdata,
				ADDR_POWER_THERMAL, MASK_POWER_THERMAL)) | set_power_thermal;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			system_error_ff <= RST_SYSTEM_ERROR;
		end else begin
			system_error_ff <= (system_error_ff & ~clr_mask(reg_addr, reg_wr, reg_wdata,
				ADDR_SYSTEM_ERROR, MASK_SYSTEM_ERROR)) | set_system_error;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_fault_ff <= RST_BUS_FAULT;
		end else begin
			bus_fault_ff <= (bus_fault_ff & ~clr_mask(reg_addr, reg_wr, reg_wdata,
				ADDR_BUS_FAULT, MASK_BUS_FAULT)) | ({1'b0, bus_fault_events} & MASK_BUS_FAULT);
		end
	end

	// Remembers the serial error level so only its rising edge sets the flag.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_err_seen_ff <= 1'b0;
		end else begin
			serial_err_seen_ff <= serial_status_error;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_count_ff <= 8'h00;
		end else if (events.frame_count_clear || frame_overflow) begin
			frame_count_ff <= 8'h00;
		end else if (events.frame_error) begin
			frame_count_ff <= frame_count_ff + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_done_ff <= 1'b0;
		end else if (reg_wr && ((reg_addr >= ADDR_PW_CFG_FIRST && reg_addr <= ADDR_PW_CFG_LAST) ||
				reg_addr == ADDR_PW_CFG_EXTRA)) begin
			config_done_ff <= 1'b0;
		end else if (wr_hit(reg_addr, reg_wr, ADDR_PW_CONFIG_4)) begin
			config_done_ff <= reg_wdata[BIT_CONFIG_DONE];
		end
	end

	assign partial_wake_err = (partial_wake_enable_req && !config_done_ff) ||
		wake_fault_ff[BIT_FRAME_ERROR_OVERFLOW_FLAG];

	// The request is judged, not the granted enable, so the flag cannot
	// oscillate once the enable has been withdrawn.
	// enable held off
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_ff <= 1'b0;
		end else begin
			enable_ff <= partial_wake_enable_req && !partial_wake_err;
		end
	end

	// Trim loader: a check is queued at reset release and on every wake exit.
	// recheck on wake
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_pending_ff <= 1'b1;
		end else if (events.wake_exit) begin
			trim_pending_ff <= 1'b1;
		end else if (trim_state_ff == TRIM_IDLE) begin
			trim_pending_ff <= 1'b0;
		end
	end

	assign trim_fail = (trim_state_ff == TRIM_WAIT) && trim_result.done && !trim_result.crc_ok &&
		(trim_tries_ff == 4'(TRIM_ATTEMPTS_P - 1));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_state_ff <= TRIM_IDLE;
			trim_tries_ff <= 4'h0;
			trim_req_ff <= 1'b0;
			trim_busy_ff <= 1'b0;
		end else begin
			trim_req_ff <= 1'b0;
			case (trim_state_ff)
				TRIM_IDLE: begin
					trim_busy_ff <= trim_pending_ff;
					if (trim_pending_ff) begin
						trim_tries_ff <= 4'h0;
						trim_state_ff <= TRIM_LOAD;
					end
				end
				TRIM_LOAD: begin
					trim_req_ff <= 1'b1;
					trim_state_ff <= TRIM_WAIT;
				end
				TRIM_WAIT: begin
					if (trim_result.done) begin
						if (trim_result.crc_ok || trim_fail) begin
							trim_busy_ff <= 1'b0;
							trim_state_ff <= TRIM_IDLE;
						end else begin
							trim_tries_ff <= trim_tries_ff + 4'h1;
							trim_state_ff <= TRIM_LOAD;
						end
					end
				end
				default: begin
					trim_state_ff <= TRIM_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		system_error_view = system_error_ff & MASK_SYSTEM_ERROR;
		system_error_view[BIT_PARTIAL_WAKE_ERR] = partial_wake_err;
	end

	always_comb begin
		summary_view = 8'h00;
		summary_view[BIT_SUM_WAKE_FAULT] = |wake_fault_ff;
		summary_view[BIT_SUM_POWER_THERMAL] = |(power_thermal_ff & MASK_POWER_THERMAL);
		summary_view[BIT_SUM_SYSTEM_ERROR] = |system_error_view;
		summary_view[BIT_SUM_BUS_FAULT] = |(bus_fault_ff & MASK_BUS_FAULT);
		summary_view[BIT_SUM_ANY] = |summary_view;
	end

	// Read data is registered, so it appears one cycle after the address.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			case (reg_addr)
				ADDR_SUMMARY: rdata_ff <= summary_view;
				ADDR_WAKE_FAULT: rdata_ff <= wake_fault_ff;
				ADDR_POWER_THERMAL: rdata_ff <= power_thermal_ff & MASK_POWER_THERMAL;
				ADDR_SYSTEM_ERROR: rdata_ff <= system_error_view;
				ADDR_BUS_FAULT: rdata_ff <= bus_fault_ff & MASK_BUS_FAULT;
				ADDR_PW_CONFIG_4: rdata_ff <= {config_done_ff, 7'h00};
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	// Global summary kept as a flop for the output.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			any_ff <= 1'b0;
		end else begin
			any_ff <= summary_view[BIT_SUM_ANY];
		end
	end

	assign reg_rdata = rdata_ff;
	assign partial_wake_enable = enable_ff;
	assign partial_wake_config_done = config_done_ff;
	assign trim_load_req = trim_req_ff;
	assign trim_busy = trim_busy_ff;
	assign any_flag = any_ff;

endmodule

// [verilog/flag_bank_pkg.sv]
package flag_bank_pkg;

	// Register offsets on the configuration port.
	localparam logic [7:0] ADDR_SUMMARY = 8'h50;
	localparam logic [7:0] ADDR_WAKE_FAULT = 8'h51;
	localparam logic [7:0] ADDR_POWER_THERMAL = 8'h52;
	localparam logic [7:0] ADDR_SYSTEM_ERROR = 8'h53;
	localparam logic [7:0] ADDR_BUS_FAULT = 8'h54;
	localparam logic [7:0] ADDR_PW_CONFIG_4 = 8'h47;
	localparam logic [7:0] ADDR_PW_CFG_FIRST = 8'h30;
	localparam logic [7:0] ADDR_PW_CFG_LAST = 8'h44;
	localparam logic [7:0] ADDR_PW_CFG_EXTRA = 8'h46;

	// Reset values.
	localparam logic [7:0] RST_WAKE_FAULT = 8'h00;
	localparam logic [7:0] RST_POWER_THERMAL = 8'h40;
	localparam logic [7:0] RST_SYSTEM_ERROR = 8'h00;
	localparam logic [7:0] RST_BUS_FAULT = 8'h00;

	// Writable masks; reserved and read-only bits are zero here.
	localparam logic [7:0] MASK_WAKE_FAULT = 8'hFF;
	localparam logic [7:0] MASK_POWER_THERMAL = 8'hDF;
	localparam logic [7:0] MASK_SYSTEM_ERROR = 8'hA1;
	localparam logic [7:0] MASK_BUS_FAULT = 8'h7F;

	// Wake and fault register bits.
	localparam int BIT_WATCHDOG = 7;
	localparam int BIT_BUS_WAKE = 6;
	localparam int BIT_LOCAL_WAKE = 5;
	localparam int BIT_WAKE_ERROR = 4;
	localparam int BIT_FRAME_ERROR_OVERFLOW_FLAG = 3;
	localparam int BIT_BUS_SILENCE = 2;
	localparam int BIT_BUS_TIMEOUT_SLEEP = 1;
	localparam int BIT_STUCK_DOMINANT = 0;

	// Power and thermal register bits.
	localparam int BIT_SLEEP_ENTRY = 7;
	localparam int BIT_POWER_ON = 6;
	localparam int BIT_UV_MAIN = 4;
	localparam int BIT_UV_IO = 3;
	localparam int BIT_UV_XCVR = 2;
	localparam int BIT_THERMAL_SD = 1;
	localparam int BIT_THERMAL_WARN = 0;

	// System error register bits.
	localparam int BIT_SERIAL_ERR = 7;
	localparam int BIT_PARTIAL_WAKE_ERR = 6;
	localparam int BIT_FAILSAFE_ENTRY = 5;
	localparam int BIT_TRIM_CHECK_ERR = 0;

	// Summary register bits.
	localparam int BIT_SUM_ANY = 7;
	localparam int BIT_SUM_WAKE_FAULT = 6;
	localparam int BIT_SUM_POWER_THERMAL = 5;
	localparam int BIT_SUM_SYSTEM_ERROR = 4;
	localparam int BIT_SUM_BUS_FAULT = 3;

	// Configuration-complete bit in the last partial wake config register.
	localparam int BIT_CONFIG_DONE = 7;

	// Frame error threshold and trim load attempts.
	localparam int FRAME_THRESHOLD = 31;
	localparam int TRIM_ATTEMPTS = 8;

	// Event strobes from the surrounding device logic, one cycle each.
	typedef struct packed {
		logic watchdog;
		logic bus_wake;
		logic local_wake;
		logic wake_window_expired;
		logic frame_error;
		logic frame_count_clear;
		logic bus_silence;
		logic stuck_dominant;
		logic uv_main;
		logic uv_io;
		logic uv_xcvr;
		logic thermal_sd;
		logic thermal_warn;
		logic failsafe_entry;
		logic wake_exit;
	} event_t;

	// Cause of a sleep entry, valid with its strobe.
	typedef struct packed {
		logic entry;
		logic by_wake_error;
		logic by_io_uv_timeout;
		logic by_io_uv_thermal;
	} sleep_entry_t;

	// Answer of the trim store loader.
	typedef struct packed {
		logic done;
		logic crc_ok;
	} trim_result_t;

endpackage

// [testbench/flag_bank_checker.sv]
`timescale 1ns/1ps
module flag_bank_checker #(
	parameter int FRAME_THRESHOLD_P = 31,
	parameter int TRIM_ATTEMPTS_P = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Device events.
	input wire flag_bank_pkg::event_t events,
	input wire flag_bank_pkg::sleep_entry_t sleep_entry,
	input wire logic serial_status_error,
	input wire logic [6:0] bus_fault_events,
	input wire logic in_sleep,
	// Partial wake, trim and summary.
	input wire logic partial_wake_enable_req,
	input wire logic partial_wake_enable,
	input wire logic partial_wake_config_done,
	input wire logic trim_load_req,
	input wire flag_bank_pkg::trim_result_t trim_result,
	input wire logic trim_busy,
	input wire logic any_flag
);
	import flag_bank_pkg::*;
	// All checks live in the one clock domain.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Writes that invalidate the partial wake setup, and the wait after a load.
	sequence s_cfg_write;
		reg_wr && ((reg_addr >= ADDR_PW_CFG_FIRST && reg_addr <= ADDR_PW_CFG_LAST)
			|| reg_addr == ADDR_PW_CFG_EXTRA);
	endsequence
	sequence s_load_wait;
		trim_busy ##1 (trim_busy && !trim_load_req);
	endsequence
	// The summary lags the flag by up to two registers, hence the short range.
	property p_wd_sum;
		events.watchdog |-> ##[2:3] any_flag;
	endproperty
	a_wd_sum: assert property (p_wd_sum) else $error("watchdog missed summary");
	property p_sleep_sum;
		sleep_entry.entry && sleep_entry.by_wake_error |-> ##[2:3] any_flag;
	endproperty
	a_sleep_sum: assert property (p_sleep_sum) else $error("sleep entry missed");
	property p_fault_sum;
		(bus_fault_events != 7'h00) |-> ##[2:3] any_flag;
	endproperty
	a_fault_sum: assert property (p_fault_sum) else $error("bus fault missed");
	property p_serial;
		$rose(serial_status_error) |-> ##[2:4] any_flag;
	endproperty
	a_serial: assert property (p_serial) else $error("serial error missed");
	property p_unmapped;
		(reg_addr == 8'h60) |=> (reg_rdata == 8'h00);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rsvd;
		(reg_addr == ADDR_SYSTEM_ERROR) |=> (reg_rdata[4:1] == 4'h0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	property p_gate;
		!partial_wake_config_done || !partial_wake_enable_req |=> !partial_wake_enable;
	endproperty
	a_gate: assert property (p_gate) else $error("enable granted in error");
	property p_cfg_clear;
		s_cfg_write |=> !partial_wake_config_done;
	endproperty
	a_cfg_clear: assert property (p_cfg_clear) else $error("config done kept");
	property p_cfg_set;
		reg_wr && reg_addr == ADDR_PW_CONFIG_4 && reg_wdata[7] |=> partial_wake_config_done;
	endproperty
	a_cfg_set: assert property (p_cfg_set) else $error("config done not set");
	property p_trim;
		trim_load_req |-> s_load_wait;
	endproperty
	a_trim: assert property (p_trim) else $error("load outside busy");
endmodule

bind transceiver_interrupt_flags flag_bank_checker #(
	.FRAME_THRESHOLD_P(FRAME_THRESHOLD_P),
	.TRIM_ATTEMPTS_P(TRIM_ATTEMPTS_P)
) u_checker (.*);

// [testbench/trim_store_model.sv]
`timescale 1ns/1ps
module trim_store_model (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Load handshake and test controls.
	input wire logic trim_load_req,
	input wire logic bad,
	input wire logic slow,
	output flag_bank_pkg::trim_result_t trim_result
);
	import flag_bank_pkg::*;
	logic [3:0] wait_ff;
	// every load is answered once, good or bad as the bench says.
	// The check bit toggles outside an answer so a stale value never helps.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 4'h0;
			trim_result <= '0;
		end else begin
			trim_result.done <= 1'b0;
			trim_result.crc_ok <= ~trim_result.crc_ok;
			if (trim_load_req) begin
				wait_ff <= slow ? 4'h6 : 4'h1;
			end else if (wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1;
				if (wait_ff == 4'h1) begin
					trim_result.done <= 1'b1;
					trim_result.crc_ok <= ~bad;
				end
			end
		end
	end
endmodule

// [testbench/transceiver_interrupt_flags_test.sv]
`timescale 1ns/1ps
module transceiver_interrupt_flags_test;
	import flag_bank_pkg::*;
	localparam int TH = 3;
	localparam int TRIES = 2;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	event_t events = '0;
	sleep_entry_t sleep_entry = '0;
	logic serial_status_error = 1'b0;
	logic [6:0] bus_fault_events = 7'h00;
	logic in_sleep = 1'b0;
	logic partial_wake_enable_req = 1'b0;
	logic partial_wake_enable;
	logic partial_wake_config_done;
	logic trim_load_req;
	trim_result_t trim_result;
	logic trim_busy;
	logic any_flag;
	logic bad = 1'b0;
	logic slow = 1'b1;
	int err_count = 0;
	int tests_run = 0;
	int loads = 0;

	// Clock, load counter, design and its trim store.
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (trim_load_req) loads++;
	transceiver_interrupt_flags #(.FRAME_THRESHOLD_P(TH), .TRIM_ATTEMPTS_P(TRIES)) DUT (.*);
	trim_store_model u_store (.*);

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data follows the address one edge later.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
		#1;
		check(what, reg_rdata, exp);
	endtask

	task automatic pulse(input int idx);
		@(posedge ref_clk);
		events <= event_t'(15'h1 << idx);
		@(posedge ref_clk);
		events <= '0;
	endtask

	// Set, survive a zero write, clear with a one.
	task automatic t_flag(input int idx, input logic [7:0] a, input logic [7:0] m);
		pulse(idx);
		rd(a, m, "flag set");
		wr(a, 8'h00);
		rd(a, m, "flag kept");
		wr(a, m);
		rd(a, 8'h00, "flag cleared");
	endtask

	// Bounded wait for the trim sequence to finish.
	task automatic t_idle;
		int n;
		n = 0;
		while (trim_busy !== 1'b0 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		check("trim idle", {7'h0, trim_busy}, 8'h00);
	endtask

	// Busy only rises at the first edge after release, so wait for it first.
	task automatic t_trim;
		repeat (2) @(posedge ref_clk);
		#1;
		check("trim busy at power-up", {7'h0, trim_busy}, 8'h01);
		t_idle();
		check("loads at power-up", 8'(loads), 8'h01);
		rd(ADDR_SYSTEM_ERROR, 8'h00, "trim ok");
		@(posedge ref_clk);
		bad <= 1'b1;
		slow <= 1'b0;
		loads = 0;
		pulse(0);
		@(posedge ref_clk);
		#1;
		check("trim restarted", {7'h0, trim_busy}, 8'h01);
		t_idle();
		check("loads on failure", 8'(loads), 8'(TRIES));
		rd(ADDR_SYSTEM_ERROR, 8'h01, "trim error");
		wr(ADDR_SYSTEM_ERROR, 8'h01);
		rd(ADDR_SYSTEM_ERROR, 8'h00, "trim error cleared");
		bad <= 1'b0;
	endtask

	task automatic t_reset;
		rd(ADDR_WAKE_FAULT, 8'h00, "first reset");
		rd(ADDR_POWER_THERMAL, 8'h40, "second reset");
		rd(ADDR_BUS_FAULT, 8'h00, "fault reset");
		rd(ADDR_SUMMARY, 8'hA0, "summary power-on");
		check("any flag power-on", {7'h0, any_flag}, 8'h01);
		wr(8'h60, 8'hFF);
		rd(8'h60, 8'h00, "unmapped");
		wr(ADDR_POWER_THERMAL, 8'h20);
		rd(ADDR_POWER_THERMAL, 8'h40, "power-on kept");
		wr(ADDR_POWER_THERMAL, 8'h40);
		rd(ADDR_POWER_THERMAL, 8'h00, "power-on cleared");
	endtask

	// Sleep entry with no cause, then with each cause in turn.
	task automatic t_sleep;
		for (int c = 0; c < 4; c++) begin
			@(posedge ref_clk);
			sleep_entry <= sleep_entry_t'({1'b1, 3'((1 << c) >> 1)});
			@(posedge ref_clk);
			sleep_entry <= '0;
			rd(ADDR_POWER_THERMAL, (c == 0) ? 8'h00 : 8'h80, "sleep entry");
			wr(ADDR_POWER_THERMAL, 8'h80);
		end
	endtask

	// A level held high sets the flag only once.
	task automatic t_serial;
		@(posedge ref_clk);
		serial_status_error <= 1'b1;
		rd(ADDR_SYSTEM_ERROR, 8'h80, "serial error");
		wr(ADDR_SYSTEM_ERROR, 8'h80);
		rd(ADDR_SYSTEM_ERROR, 8'h00, "serial level held");
		@(posedge ref_clk);
		serial_status_error <= 1'b0;
	endtask

	task automatic t_frame;
		repeat (TH) pulse(10);
		pulse(9);
		repeat (TH) pulse(10);
		rd(ADDR_WAKE_FAULT, 8'h00, "below threshold");
		pulse(10);
		rd(ADDR_WAKE_FAULT, 8'h08, "frame overflow");
		@(posedge ref_clk);
		partial_wake_enable_req <= 1'b1;
		wr(ADDR_PW_CONFIG_4, 8'h80);
		rd(ADDR_SYSTEM_ERROR, 8'h40, "overflow error");
		check("enable held off", {7'h0, partial_wake_enable}, 8'h00);
		check("config done set", {7'h0, partial_wake_config_done}, 8'h01);
		wr(ADDR_WAKE_FAULT, 8'h08);
		rd(ADDR_WAKE_FAULT, 8'h00, "overflow cleared");
	endtask

	// Enable with configuration done, silence in sleep, then reconfigure.
	task automatic t_partial;
		rd(ADDR_SYSTEM_ERROR, 8'h00, "configured");
		check("enabled", {7'h0, partial_wake_enable}, 8'h01);
		@(posedge ref_clk);
		in_sleep <= 1'b1;
		pulse(8);
		rd(ADDR_WAKE_FAULT, 8'h06, "silence in sleep");
		wr(ADDR_WAKE_FAULT, 8'h06);
		wr(ADDR_PW_CFG_FIRST, 8'h00);
		rd(ADDR_SYSTEM_ERROR, 8'h40, "config dropped");
		check("enable dropped", {7'h0, partial_wake_enable}, 8'h00);
		check("config done output", {7'h0, partial_wake_config_done}, 8'h00);
		// Range ends: 45h lies outside the clearing set, 44h and 46h inside it.
		wr(ADDR_PW_CONFIG_4, 8'h80);
		wr(8'h45, 8'h00);
		rd(ADDR_PW_CONFIG_4, 8'h80, "config kept by 45h");
		wr(ADDR_PW_CFG_EXTRA, 8'h00);
		rd(ADDR_PW_CONFIG_4, 8'h00, "config cleared by 46h");
		wr(ADDR_PW_CONFIG_4, 8'h80);
		wr(ADDR_PW_CFG_LAST, 8'h00);
		rd(ADDR_PW_CONFIG_4, 8'h00, "config cleared by 44h");
		@(posedge ref_clk);
		partial_wake_enable_req <= 1'b0;
		in_sleep <= 1'b0;
	endtask

	task automatic t_fault;
		@(posedge ref_clk);
		bus_fault_events <= 7'h7F;
		@(posedge ref_clk);
		bus_fault_events <= 7'h00;
		rd(ADDR_BUS_FAULT, 8'h7F, "bus fault");
		rd(ADDR_SUMMARY, 8'h88, "summary fault");
		check("any flag fault", {7'h0, any_flag}, 8'h01);
		wr(ADDR_BUS_FAULT, 8'hAA);
		rd(ADDR_BUS_FAULT, 8'h55, "partial clear");
		wr(ADDR_BUS_FAULT, 8'hFF);
		rd(ADDR_SUMMARY, 8'h00, "summary idle");
		check("any flag idle", {7'h0, any_flag}, 8'h00);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence; flags checked one source at a time, except the seven bus faults, set all at once.
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_trim();
		t_reset();
		t_flag(14, ADDR_WAKE_FAULT, 8'h80);
		t_flag(13, ADDR_WAKE_FAULT, 8'h40);
		t_flag(12, ADDR_WAKE_FAULT, 8'h20);
		pulse(11);
		rd(ADDR_WAKE_FAULT, 8'h00, "wake error awake");
		@(posedge ref_clk);
		in_sleep <= 1'b1;
		t_flag(11, ADDR_WAKE_FAULT, 8'h10);
		@(posedge ref_clk);
		in_sleep <= 1'b0;
		t_flag(8, ADDR_WAKE_FAULT, 8'h04);
		t_flag(7, ADDR_WAKE_FAULT, 8'h01);
		for (int i = 2; i < 7; i++) t_flag(i, ADDR_POWER_THERMAL, 8'(1 << (i - 2)));
		t_flag(1, ADDR_SYSTEM_ERROR, 8'h20);
		t_sleep();
		t_serial();
		t_frame();
		t_partial();
		t_fault();
		results();
	end

	// The whole run needs a few hundred cycles.
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("ERROR watchdog expected finish seen hang");
		results();
	end
endmodule
